/* File: fcg_pkg.sv */
// Purpose: Shared constants and types for the fault close guard.
// Assumes: 10 MHz clock, APB register access, 1 ms internal time base.
// Notes: Times are kept in milliseconds.
// Notes on behaviour
// - A rising edge on arm_input starts the guard window and its release timer.
// - The window length is a release time of 0 to 1800 s, one second after reset.
// - A protection start while the window runs raises the trip output at once.
// - Any one of several protection start inputs is enough to trip, with no delay.
// - While guard_block_input is high the window cannot start; a window already running still gives active and trip.
// - The node operating mode is On, Blocked, Test, Test/Blocked or Off, On after reset.
// - With forcing enabled the reported state is forced to Normal, Blocked, Active or Trip.
// - A condition status of Normal, Init, Active, Trip or Blocked shows the present state.
// - The release time used is the one of the currently selected setting group.
// - Init, block, active and trip give timestamped ON and OFF events, selectable per event.
// - Separate clearable counters count init, block, active and trip events.
// - The twelve newest records are kept, taken on the ON edge of activation or trip.
// - A record holds event name, timestamp, setting group, remaining and active time.
package fcg_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_CYC_DEF = CLK_HZ / MS_PER_S;
  localparam int REL_MAX_S = 1800;
  localparam int REL_MAX_MS = REL_MAX_S * MS_PER_S;
  localparam int REL_DEF_S = 1;
  localparam int TW = 21;
  localparam logic [TW-1:0] REL_DEF_MS = TW'(REL_DEF_S * MS_PER_S);
  localparam logic [TW-1:0] REL_MAX = TW'(REL_MAX_MS);
  localparam int NSTART = 4;
  localparam int NGRP = 8;
  localparam int NEV = 4;
  localparam int REC_N = 12;
  localparam int CW = 16;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_EVSEL = 8'h08;
  localparam logic [7:0] OFS_IRQ = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_CCLR = 8'h14;
  localparam logic [7:0] OFS_CNT0 = 8'h18;
  localparam logic [7:0] OFS_TREM = 8'h28;
  localparam logic [7:0] OFS_ACTT = 8'h2C;
  localparam logic [7:0] OFS_TIME = 8'h30;
  localparam logic [7:0] OFS_RIDX = 8'h34;
  localparam logic [7:0] OFS_RHDR = 8'h38;
  localparam logic [7:0] OFS_RTS = 8'h3C;
  localparam logic [7:0] OFS_RREM = 8'h40;
  localparam logic [7:0] OFS_RACT = 8'h44;
  localparam logic [7:0] OFS_REL0 = 8'h60;
  localparam int EV_INIT = 0;
  localparam int EV_BLOCK = 1;
  localparam int EV_ACT = 2;
  localparam int EV_TRIP = 3;
  typedef enum logic [2:0] {
    MODE_ON = 3'h0, MODE_BLK = 3'h1, MODE_TEST = 3'h2, MODE_TBLK = 3'h3, MODE_OFF = 3'h4
  } fcg_mode_t;
  typedef enum logic [1:0] {
    FRC_NORMAL = 2'h0, FRC_BLOCKED = 2'h1, FRC_ACTIVE = 2'h2, FRC_TRIP = 2'h3
  } fcg_force_t;
  typedef enum logic [2:0] {
    COND_NORMAL = 3'h0, COND_INIT = 3'h1, COND_ACTIVE = 3'h2, COND_TRIP = 3'h3,
    COND_BLOCKED = 3'h4
  } fcg_cond_t;
  typedef struct packed {
    fcg_force_t frc;
    logic fen;
    logic pad;
    fcg_mode_t mode;
  } fcg_ctrl_t;
  localparam fcg_ctrl_t CTRL_RST = '{FRC_NORMAL, 1'b0, 1'b0, MODE_ON};
  typedef struct packed {
    logic arm;
    logic block;
    logic [NSTART-1:0] start;
  } fcg_in_t;
  typedef struct packed {
    logic [NEV-1:0] on;
    logic [NEV-1:0] off;
    logic [31:0] stamp;
  } fcg_ev_t;
  typedef struct packed {
    logic [1:0] name;
    logic [2:0] grp;
    logic [31:0] stamp;
    logic [TW-1:0] trem;
    logic [31:0] actt;
  } fcg_rec_t;
endpackage

/* File: fcg_rec_mem.sv */
// Purpose: Twelve-entry record store with registered read data.
// Assumes: One write port and one read port on the same clock.
// Notes: Read data follow the read address one cycle later.
`timescale 1ns/100ps
module fcg_rec_mem
  import fcg_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Write side.
  input wire logic we,
  input wire logic [3:0] waddr,
  input fcg_pkg::fcg_rec_t wdata,
  // Read side.
  input wire logic [3:0] raddr,
  output fcg_pkg::fcg_rec_t rdata
);
  fcg_rec_t mem [REC_N];

  always_ff @(posedge clk) begin
    if (we && waddr < 4'(REC_N)) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (raddr < 4'(REC_N)) begin
      rdata <= mem[raddr];
    end else begin
      rdata <= '0;
    end
  end
endmodule

/* File: fcg_guard.sv */
// Purpose: Fault close guard with APB registers, events, counters and record log.
// Assumes: Inputs come from logic on clk; APB slave answers with no wait state.
// Notes: Trip and active outputs are suppressed in the two test modes.
`timescale 1ns/100ps
module fcg_guard
  import fcg_pkg::*;
#(
  parameter int TICK_CYC = fcg_pkg::TICK_CYC_DEF
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Guard inputs and setting group.
  input fcg_pkg::fcg_in_t guard_in,
  input wire logic [2:0] setting_group_select,
  // Guard outputs.
  output logic guard_active_output,
  output logic guard_trip_output,
  output fcg_pkg::fcg_ev_t ev_out,
  output logic irq
);
  import fcg_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_ARMED = 2'h1, ST_TRIP = 2'h2
  } fcg_state_t;

  fcg_state_t state;
  fcg_ctrl_t ctrl;
  fcg_cond_t cond;
  fcg_cond_t next_cond;
  fcg_rec_t rec_rd;
  fcg_rec_t rec_wr;
  logic [TW-1:0] rel_t [NGRP];
  logic [TW-1:0] rel_sel;
  logic [TW-1:0] trem;
  logic [31:0] actt;
  logic [31:0] ms_time;
  logic [13:0] tcnt;
  logic tick;
  logic arm_prev;
  logic arm_rise;
  logic run;
  logic blk;
  logic test;
  logic start_any;
  logic window;
  logic expire;
  logic [NEV-1:0] lvl;
  logic [NEV-1:0] next_lvl;
  logic [NEV-1:0] ev_on;
  logic [NEV-1:0] ev_off;
  logic [2*NEV-1:0] evsel;
  logic [NEV-1:0] irq_stat;
  logic [NEV-1:0] irq_mask;
  logic [CW-1:0] cnt [NEV];
  logic [NEV-1:0] cnt_clr;
  logic [3:0] wptr;
  logic [3:0] rec_cnt;
  logic [3:0] rec_idx;
  logic rec_we;
  logic wr;
  logic rd_ok;

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_ok;

  // Time base: one enable pulse per millisecond and a free running stamp.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tcnt <= '0;
    end else if (tcnt >= 14'(TICK_CYC - 1)) begin
      tcnt <= '0;
    end else begin
      tcnt <= tcnt + 14'h1;
    end
  end
  assign tick = (tcnt >= 14'(TICK_CYC - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ms_time <= '0;
    end else if (tick) begin
      ms_time <= ms_time + 32'h1;
    end
  end

  // Mode decode.
  assign run = (ctrl.mode == MODE_ON) || (ctrl.mode == MODE_BLK) ||
               (ctrl.mode == MODE_TEST) || (ctrl.mode == MODE_TBLK);
  assign blk = guard_in.block || (ctrl.mode == MODE_BLK) || (ctrl.mode == MODE_TBLK);
  assign test = (ctrl.mode == MODE_TEST) || (ctrl.mode == MODE_TBLK);
  assign start_any = |guard_in.start;
  assign rel_sel = rel_t[setting_group_select];
  assign window = (state != ST_IDLE);
  assign expire = window && tick && (trem <= TW'(1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arm_prev <= 1'b0;
    end else begin
      arm_prev <= guard_in.arm;
    end
  end
  assign arm_rise = guard_in.arm && !arm_prev;

  // Guard sequence.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else if (!run) begin
      state <= ST_IDLE;
    end else if (arm_rise && !blk && rel_sel != '0) begin
      state <= start_any ? ST_TRIP : ST_ARMED;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        ST_ARMED: begin
          if (expire) begin
            state <= ST_IDLE;
          end else if (start_any) begin
            state <= ST_TRIP;
          end
        end
        ST_TRIP: begin
          if (expire) begin
            state <= ST_IDLE;
          end else if (!start_any) begin
            state <= ST_ARMED;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Remaining release time and elapsed active time.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trem <= '0;
    end else if (!run) begin
      trem <= '0;
    end else if (arm_rise && !blk && rel_sel != '0) begin
      trem <= rel_sel;
    end else if (window && tick) begin
      trem <= expire ? '0 : trem - TW'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      actt <= '0;
    end else if (run && arm_rise && !blk && rel_sel != '0) begin
      actt <= '0;
    end else if (window && tick) begin
      actt <= actt + 32'h1;
    end
  end

  // Reported levels, with forcing taking precedence.
  always_comb begin
    next_lvl = '0;
    if (ctrl.fen) begin
      next_lvl[EV_BLOCK] = (ctrl.frc == FRC_BLOCKED);
      next_lvl[EV_ACT] = (ctrl.frc == FRC_ACTIVE) || (ctrl.frc == FRC_TRIP);
      next_lvl[EV_TRIP] = (ctrl.frc == FRC_TRIP);
    end else if (run) begin
      next_lvl[EV_INIT] = guard_in.arm;
      next_lvl[EV_BLOCK] = blk;
      next_lvl[EV_ACT] = window;
      next_lvl[EV_TRIP] = (state == ST_TRIP);
    end
  end

  always_comb begin
    if (next_lvl[EV_TRIP]) begin
      next_cond = COND_TRIP;
    end else if (next_lvl[EV_ACT]) begin
      next_cond = COND_ACTIVE;
    end else if (next_lvl[EV_BLOCK]) begin
      next_cond = COND_BLOCKED;
    end else if (next_lvl[EV_INIT]) begin
      next_cond = COND_INIT;
    end else begin
      next_cond = COND_NORMAL;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lvl <= '0;
      cond <= COND_NORMAL;
      guard_active_output <= 1'b0;
      guard_trip_output <= 1'b0;
    end else begin
      lvl <= next_lvl;
      cond <= next_cond;
      guard_active_output <= next_lvl[EV_ACT] && !test;
      guard_trip_output <= next_lvl[EV_TRIP] && !test;
    end
  end

  // Events, stamped with the millisecond time.
  assign ev_on = next_lvl & ~lvl;
  assign ev_off = ~next_lvl & lvl;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev_out <= '0;
    end else begin
      ev_out.on <= ev_on & evsel[NEV-1:0];
      ev_out.off <= ev_off & evsel[2*NEV-1:NEV];
      ev_out.stamp <= ms_time;
    end
  end

  // Event counters; a clear in the same cycle as an event leaves a count of one.
  generate
    for (genvar i = 0; i < NEV; i++) begin : g_cnt
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          cnt[i] <= '0;
        end else if (cnt_clr[i]) begin
          cnt[i] <= ev_on[i] ? CW'(1) : '0;
        end else if (ev_on[i]) begin
          cnt[i] <= cnt[i] + CW'(1);
        end
      end
    end
  endgenerate
  assign cnt_clr = (wr && paddr == OFS_CCLR) ? pwdata[NEV-1:0] : '0;

  // Interrupt status: set wins over a write-one clear.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= '0;
    end else if (wr && paddr == OFS_IRQ) begin
      irq_stat <= (irq_stat & ~pwdata[NEV-1:0]) | ev_on;
    end else begin
      irq_stat <= irq_stat | ev_on;
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // Record log: ring of twelve, written on the ON edge of activation or trip.
  assign rec_we = ev_on[EV_ACT] || ev_on[EV_TRIP];
  assign rec_wr = '{ev_on[EV_TRIP] ? 2'(EV_TRIP) : 2'(EV_ACT),
                    setting_group_select, ms_time, trem, actt};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr <= '0;
      rec_cnt <= '0;
    end else if (rec_we) begin
      wptr <= (wptr == 4'(REC_N - 1)) ? '0 : wptr + 4'h1;
      rec_cnt <= (rec_cnt == 4'(REC_N)) ? rec_cnt : rec_cnt + 4'h1;
    end
  end

  fcg_rec_mem u_mem (
    .clk(clk),
    .we(rec_we),
    .waddr(wptr),
    .wdata(rec_wr),
    .raddr(rec_idx),
    .rdata(rec_rd)
  );

  // Register writes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= CTRL_RST;
      evsel <= '1;
      irq_mask <= '0;
      rec_idx <= '0;
    end else if (wr) begin
      case (paddr)
        OFS_CTRL: ctrl <= fcg_ctrl_t'(pwdata[6:0]);
        OFS_EVSEL: evsel <= pwdata[2*NEV-1:0];
        OFS_MASK: irq_mask <= pwdata[NEV-1:0];
        OFS_RIDX: rec_idx <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  generate
    for (genvar g = 0; g < NGRP; g++) begin : g_rel
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          rel_t[g] <= REL_DEF_MS;
        end else if (wr && paddr == OFS_REL0 + 8'(4 * g)) begin
          rel_t[g] <= (pwdata[TW-1:0] > REL_MAX) ? REL_MAX : pwdata[TW-1:0];
        end
      end
    end
  endgenerate

  // Register reads.
  always_comb begin
    prdata = '0;
    rd_ok = 1'b1;
    if (paddr >= OFS_REL0 && paddr < OFS_REL0 + 8'(4 * NGRP) && paddr[1:0] == 2'h0) begin
      prdata = 32'(rel_t[3'(paddr[4:2])]);
    end else if (paddr >= OFS_CNT0 && paddr < OFS_TREM && paddr[1:0] == 2'h0) begin
      prdata = 32'(cnt[2'(paddr[3:2] - OFS_CNT0[3:2])]);
    end else begin
      case (paddr)
        OFS_CTRL: prdata = 32'(ctrl);
        OFS_STAT: prdata = {16'h0, rec_cnt, wptr, 3'h0, cond, window, lvl[EV_TRIP]};
        OFS_EVSEL: prdata = 32'(evsel);
        OFS_IRQ: prdata = 32'(irq_stat);
        OFS_MASK: prdata = 32'(irq_mask);
        OFS_CCLR: prdata = '0;
        OFS_TREM: prdata = 32'(trem);
        OFS_ACTT: prdata = actt;
        OFS_TIME: prdata = ms_time;
        OFS_RIDX: prdata = 32'(rec_idx);
        OFS_RHDR: prdata = {27'h0, rec_rd.grp, rec_rd.name};
        OFS_RTS: prdata = rec_rd.stamp;
        OFS_RREM: prdata = 32'(rec_rd.trem);
        OFS_RACT: prdata = rec_rd.actt;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // Checks.
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  arm_opens_a: assert property (
    (run && arm_rise && !blk && rel_sel != '0) |=> window && trem == $past(rel_sel))
    else $error("arming edge did not open the window");
  rel_bound_a: assert property (trem <= REL_MAX)
    else $error("remaining time above limit");
  start_trips_a: assert property (
    (state == ST_ARMED && start_any && !expire && run && !arm_rise && !ctrl.fen && !test)
      |=> ##1 guard_trip_output)
    else $error("start in window did not trip");
  trip_cause_a: assert property (
    (!ctrl.fen && $rose(lvl[EV_TRIP])) |-> $past(start_any, 2))
    else $error("trip without a start input");
  block_stops_a: assert property ((blk && !window) |=> !window)
    else $error("window opened while blocked");
  off_quiet_a: assert property ((ctrl.mode == MODE_OFF && !ctrl.fen) |=> ##1 !lvl[EV_ACT])
    else $error("active while mode off");
  force_trip_a: assert property (
    (ctrl.fen && ctrl.frc == FRC_TRIP) |=> cond == COND_TRIP && lvl[EV_ACT])
    else $error("forced trip not reported");
  cond_trip_a: assert property (lvl[EV_TRIP] |-> cond == COND_TRIP)
    else $error("condition does not show trip");
  group_pick_a: assert property (
    (run && arm_rise && !blk && rel_t[setting_group_select] != '0)
      |=> trem == $past(rel_t[setting_group_select]))
    else $error("release time not from selected group");
  event_on_a: assert property ((ev_on[EV_TRIP] && evsel[EV_TRIP]) |=> ev_out.on[EV_TRIP])
    else $error("trip ON event missing");
  count_step_a: assert property (
    (ev_on[EV_INIT] && !cnt_clr[EV_INIT]) |=> cnt[EV_INIT] == $past(cnt[EV_INIT]) + CW'(1))
    else $error("init counter did not step");
  ring_wrap_a: assert property ((rec_we && wptr == 4'(REC_N - 1)) |=> wptr == '0)
    else $error("record pointer did not wrap");
  expire_idle_a: assert property ((expire && run && !arm_rise) |=> !window)
    else $error("window did not close on expiry");

  trip_seen_c: cover property ($rose(guard_trip_output));
  expiry_seen_c: cover property (expire && state == ST_ARMED);
  wrap_seen_c: cover property (rec_we && wptr == 4'(REC_N - 1));
  forced_seen_c: cover property (ctrl.fen && ctrl.frc == FRC_ACTIVE);
endmodule

/* File: fcg_io_model.sv */
// Purpose: Model of the relay logic that drives the guard's binary inputs.
// Assumes: The bench requests levels; they reach the guard one clock later.
// Notes: All inputs are low while the relay logic is held in reset.
`timescale 1ns/100ps
module fcg_io_model
  import fcg_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Requested levels.
  input wire logic arm_req,
  input wire logic block_req,
  input wire logic [fcg_pkg::NSTART-1:0] start_req,
  // Levels towards the guard.
  output fcg_pkg::fcg_in_t guard_in
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      guard_in <= '0;
    end else begin
      guard_in.arm <= arm_req;
      guard_in.block <= block_req;
      guard_in.start <= start_req;
    end
  end
endmodule

/* File: tb_close_onto_fault_guard.sv */
// Purpose: Self-checking bench for the fault close guard.
// Assumes: TICK_CYC of 10, so one millisecond lasts ten clocks.
// Notes: Expected values are queued by the driver and compared by a monitor.
`timescale 1ns/100ps
module tb_close_onto_fault_guard;
  import fcg_pkg::*;
  localparam int TICK = 10;
  localparam int REL = 5;
  // The millisecond stamp starts counting at the first edge after reset release.
  localparam int T0 = 13;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, obs;
  logic rerr, active, trip, arm_req, block_req;
  logic [3:0] start_req;
  logic [2:0] setting_group_select, g;
  fcg_in_t guard_in;
  fcg_ev_t ev_out;
  logic [31:0] exp_q[$];
  string name_q[$];
  event obs_ev;
  int n_errors, comparisons, cycles;

  fcg_io_model u_io (.clk(clk), .resetn(resetn), .arm_req(arm_req),
    .block_req(block_req), .start_req(start_req), .guard_in(guard_in));
  fcg_guard #(.TICK_CYC(TICK)) u_dut (.clk(clk), .resetn(resetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .guard_in(guard_in),
    .setting_group_select(setting_group_select), .guard_active_output(active),
    .guard_trip_output(trip), .ev_out(ev_out), .irq(irq));

  always #50 clk = ~clk;

  task print_verdict;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A hung handshake or check ends the run here.
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  always @(obs_ev) begin
    logic [31:0] e;
    string n;
    e = exp_q.pop_front();
    n = name_q.pop_front();
    comparisons++;
    if (obs !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, obs);
    end
  end

  task chk(input logic [31:0] e, input logic [31:0] v, input string n);
    exp_q.push_back(e);
    name_q.push_back(n);
    obs = v;
    -> obs_ev;
    #1;
  endtask

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
    apb(a, 1'b0, 32'h0);
    chk(e, rdat & m, n);
  endtask

  // Arm edge, then the active output and its ON event two edges after sampling.
  task arm(input logic [1:0] e);
    @(posedge clk);
    arm_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(32'h0, {30'h0, active, ev_out.on[EV_ACT]}, "active_early");
    @(posedge clk);
    arm_req <= 1'b0;
    #1 chk({30'h0, e}, {30'h0, active, ev_out.on[EV_ACT]}, "active_rise");
  endtask

  task trip_at(input int k);
    @(posedge clk);
    start_req[k] <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(32'h0, {30'h0, trip, ev_out.on[EV_TRIP]}, "trip_early");
    @(posedge clk);
    start_req <= 4'h0;
    #1 chk(32'h3, {30'h0, trip, ev_out.on[EV_TRIP]}, "trip_rise");
    chk((cycles - T0) / TICK, ev_out.stamp, "trip_stamp");
    // The start drops at the guard one edge later, the trip level two edges after that.
    repeat (3) @(posedge clk);
    #1 chk(32'h1, {30'h0, trip, ev_out.off[EV_TRIP]}, "trip_fall");
  endtask

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {psel, penable, pwrite, arm_req, block_req} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    start_req = 4'h0;
    setting_group_select = 3'h0;
    n_errors = 0;
    comparisons = 0;
    cycles = 0;
    void'($urandom(32'hc99bce1b));
    g = 3'($urandom_range(7, 1));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(OFS_CTRL, 32'h0, '1, "ctrl_reset");
    rd(OFS_EVSEL, 32'hFF, '1, "evsel_reset");
    rd(OFS_REL0, 32'd1000, '1, "rel_reset");
    rd(8'h50, 32'h0, '1, "unmapped_data");
    chk(32'h1, {31'h0, rerr}, "unmapped_err");
    wr(OFS_REL0, 32'hFFFFFFFF);
    rd(OFS_REL0, 32'h001B7740, '1, "rel_clamp");
    wr(OFS_REL0 + {3'h0, g, 2'h0}, REL);
    @(posedge clk);
    setting_group_select <= g;
    arm(2'h3);
    repeat ((REL - 1) * TICK - 3) @(posedge clk);
    #1 chk(32'h1, {31'h0, active}, "window_hold");
    repeat (20) @(posedge clk);
    #1 chk(32'h0, {31'h0, active}, "window_end");
    for (int k = 0; k < NSTART; k++) begin
      arm(2'h3);
      repeat (4) @(posedge clk);
      trip_at(k);
      repeat (60) @(posedge clk);
    end
    rd(OFS_CNT0 + 8'hC, 32'd4, '1, "trip_count");
    rd(OFS_CNT0 + 8'h8, 32'd5, '1, "active_count");
    wr(OFS_CCLR, 32'h8);
    rd(OFS_CNT0 + 8'hC, 32'h0, '1, "trip_cleared");
    rd(OFS_STAT, 32'h9000, 32'hF000, "record_count");
    wr(OFS_RIDX, 32'h0);
    rd(OFS_RHDR, {27'h0, g, 2'h2}, 32'h1F, "record0_head");
    wr(OFS_RIDX, 32'h2);
    rd(OFS_RHDR, {27'h0, g, 2'h3}, 32'h1F, "record2_head");
    chk(32'h0, {31'h0, irq}, "irq_masked");
    wr(OFS_MASK, 32'h8);
    #1 chk(32'h1, {31'h0, irq}, "irq_raised");
    wr(OFS_IRQ, 32'h8);
    #1 chk(32'h0, {31'h0, irq}, "irq_cleared");
    @(posedge clk);
    block_req <= 1'b1;
    arm(2'h0);
    @(posedge clk);
    block_req <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk(32'h0, {31'h0, active}, "no_late_start");
    // Test mode still opens the window and reports its events, but silences the outputs.
    for (int m = 1; m <= 5; m++) begin
      wr(OFS_CTRL, m);
      rd(OFS_CTRL, m, '1, "mode_readback");
      arm((m == 2) ? 2'h1 : 2'h0);
      repeat (60) @(posedge clk);
    end
    // Force values 0 to 3 report Normal, Blocked, Active and Trip.
    for (int f = 0; f < 4; f++) begin
      wr(OFS_CTRL, 32'h10 | (f << 5));
      repeat (3) @(posedge clk);
      #1 chk({30'h0, f == 3, f >= 2}, {30'h0, trip, active}, "forced_out");
      rd(OFS_STAT, ((f == 1) ? 4 : f) << 2, 32'h1C, "forced_cond");
    end
    // Leaving forced trip with OFF storage of trip deselected: only the active OFF shows.
    wr(OFS_EVSEL, 32'h7F);
    wr(OFS_CTRL, 32'h0);
    @(posedge clk);
    #1 chk(32'h2, {29'h0, trip, ev_out.off[EV_ACT], ev_out.off[EV_TRIP]}, "off_select");
    print_verdict();
  end
endmodule
